// >>> rtl/slp_pkg.sv
// Shared constants and types of the sleep and read-parameter controller.
// Assumes a 100 MHz system clock; all times are converted to cycles here.
package slp_pkg;

	// ----------------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------------
	localparam logic [7:0] OP_DEEP_SLEEP_ENTER      = 8'hb9;
	localparam logic [7:0] OP_DEEP_SLEEP_RELEASE    = 8'hab;
	localparam logic [7:0] OP_SET_RDPARAM_PERSIST   = 8'h65;
	localparam logic [7:0] OP_SET_RDPARAM_VOLATILE  = 8'hc0;
	localparam logic [7:0] OP_SET_RDPARAM_VOLATILE2 = 8'h63;
	localparam logic [7:0] OP_SET_EXTPARAM_PERSIST  = 8'h85;
	localparam logic [7:0] OP_SET_EXTPARAM_VOLATILE = 8'h83;
	localparam logic [7:0] OP_GET_RDPARAM           = 8'h61;
	localparam logic [7:0] OP_GET_EXTPARAM          = 8'h81;

	// ----------------------------------------------------------------------
	// Register layout and reset values
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic       pin_function_select;
		logic [3:0] dummy_cycles;
		logic       wrap_enable_bit;
		logic       wrap_length_high;
		logic       wrap_length_low;
	} slp_rdparam_s;

	localparam logic [7:0] RDPARAM_RESET  = 8'h00;
	localparam int         EXT_DRIVE_LSB  = 5;
	localparam int         EXT_WIP_BIT    = 0;
	localparam logic [2:0] DRIVE_RESET    = 3'h5;
	localparam int         FRAME_BITS_MAX = 16;
	localparam int         OPCODE_BITS    = 8;

	// Frame as seen by the system clock after chip select rises.
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] data;
		logic       exact_opcode;
		logic       has_opcode;
		logic       has_data;
	} slp_frame_s;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int SLEEP_ENTRY_NS     = 3000;
	localparam int WAKE_NS            = 5000;
	localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1)
		? 1 : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
	localparam int WAKE_CYCLES        = (WAKE_NS / CLK_PERIOD_NS < 1)
		? 1 : WAKE_NS / CLK_PERIOD_NS;
	localparam int TIMER_W            = 16;

	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_ENTERING,
		ST_ASLEEP,
		ST_WAKING
	} slp_state_e;

	function automatic logic is_rdparam_volatile(input logic [7:0] op);
		is_rdparam_volatile = (op == OP_SET_RDPARAM_VOLATILE) ||
			(op == OP_SET_RDPARAM_VOLATILE2);
	endfunction

endpackage

// >>> rtl/slp_sync.sv
// Two-flop level synchroniser, one independent stage per bit.
// Assumes every bit is a slow level; multi-bit values are not kept coherent.
`timescale 1ns/1ns
module slp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// >>> rtl/slp_wrap_addr.sv
// Read address sequencer: linear or wrapping inside an aligned burst.
// Assumes start and step pulses come from logic on the same clock.
`timescale 1ns/1ns
module slp_wrap_addr #(
	parameter int ADDR_W = 25
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Sequencing
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] start_addr,
	input  wire logic              step,
	input  wire logic [2:0]        wrap_cfg,
	output logic      [ADDR_W-1:0] addr_q
);

	initial begin
		if (ADDR_W < 8)
			$error("ADDR_W must cover one 256-byte page");
	end

	// Wrapping only touches the low bits, so a burst never leaves its page.
	function automatic logic [ADDR_W-1:0] next_addr(
		input logic [ADDR_W-1:0] a,
		input logic [2:0]        cfg
	);
		logic [7:0] mask;
		logic [7:0] lo;
		mask = 8'h00;
		lo   = 8'h00;
		if (!cfg[2]) begin
			next_addr = a + ADDR_W'(1);
		end else begin
			mask = 8'((8 << cfg[1:0]) - 1);
			lo   = (a[7:0] & ~mask) | ((a[7:0] + 8'h01) & mask);
			next_addr = {a[ADDR_W-1:8], lo};
		end
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			addr_q <= '0;
		else if (start)
			addr_q <= start_addr;
		else if (step)
			addr_q <= next_addr(addr_q, wrap_cfg);
	end

endmodule

// >>> rtl/slp_ctrl.sv
// Deep-sleep entry and release, read-parameter registers and their
// readback, for a serial flash command port in single or four-line mode.
// Assumes the host stops SCK while CS_N is high and holds CS_N high for
// at least four CLK periods between frames.
`timescale 1ns/1ns

// Overview of operation
// - Sleeping device ignores all write-type instructions.
// - Sleep needs whole opcode before chip select.
// - Sleep entered within entry delay after deselect.
// - While asleep only release opcode is recognised.
// - Instructions accepted only after wake delay elapses.
// - Release ignored while write is in progress.
// - Read parameters hold wrap, dummy, pin select.
// - Dedicated reset pin ignores pin select bit.
// - Persistent write updates both copies, volatile one.
// - Wrap reads cycle inside aligned burst boundary.
// - Without wrap, address increments across array.
// - Wrap codes 0-3 linear, 4-7 give 8-64.
// - Wrap persists until rewritten, sleep or reset.
// - Every read applies configured wrap behaviour.
// - Chip select high ends a wrapping read; here CS_N is not seen, READ_ADDR steps while READ_NEXT is high.
// - Extended register has three-bit drive strength field.
// - Extended persistent write updates both copies.
// - Read-parameter readback returns the volatile copy.
// - Extended readback works during writes, shows busy.
// - Sleep opcode accepted in serial and quad.
// - Quad mode sends two nibbles, high first.
module slp_ctrl
	import slp_pkg::*;
#(
	parameter int   ADDR_W              = 25,
	parameter logic DEDICATED_RESET_PIN = 1'b0
) (
	// System clock and reset
	input  wire logic              CLK,
	input  wire logic              RST,
	// Serial link pins
	input  wire logic              SCK,
	input  wire logic              CS_N,
	input  wire logic [3:0]        IO_IN,
	output logic      [3:0]        IO_OUT,
	output logic      [3:0]        IO_OE,
	// Device status from the rest of the device
	input  wire logic              QPI_MODE,
	input  wire logic              WRITE_IN_PROGRESS,
	// Read address sequencing
	input  wire logic              READ_START,
	input  wire logic [ADDR_W-1:0] READ_START_ADDR,
	input  wire logic              READ_NEXT,
	output logic      [ADDR_W-1:0] READ_ADDR,
	// Configuration and state outputs
	output slp_rdparam_s           RD_PARAM,
	output logic      [7:0]        EXT_PARAM,
	output logic                   SHARED_PIN_IS_RESET,
	output logic                   DEEP_SLEEP,
	output logic                   WRITE_LOCK,
	output logic                   CMD_READY
);

	initial begin
		if (ADDR_W < 8 || ADDR_W > 32)
			$error("ADDR_W out of range 8..32");
	end

	// ----------------------------------------------------------------------
	// Link domain: frame capture on SCK
	// ----------------------------------------------------------------------
	logic       link_rst;
	logic       first_q;
	logic       frame_tog_q;
	logic [4:0] bits_q;
	logic [15:0] shift_q;
	logic [1:0] lnk_sync;
	logic       qpi_l;
	logic       wip_l;
	logic       asleep_l;
	logic [4:0] bits_base;
	logic [15:0] shift_base;
	logic [4:0] bits_next;
	logic [15:0] shift_next;
	logic       opcode_done;
	logic [7:0] out_q;
	logic       out_busy;
	logic [7:0] rb_v;

	// Chip select high ends every driven output and every readback.
	assign link_rst = RST | CS_N;

	slp_sync #(
		.W(2)
	) u_sync_link (
		.clk(SCK),
		.rst(RST),
		.d  ({QPI_MODE, WRITE_IN_PROGRESS}),
		.q  (lnk_sync)
	);
	assign qpi_l    = lnk_sync[1];
	assign wip_l    = lnk_sync[0];
	assign asleep_l = WRITE_LOCK;

	// Set while deselected so the first edge of a frame restarts counting.
	always_ff @(posedge SCK or posedge link_rst) begin
		if (link_rst)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	always_comb begin
		bits_base  = first_q ? 5'h00 : bits_q;
		shift_base = first_q ? 16'h0000 : shift_q;
		bits_next  = bits_base;
		shift_next = shift_base;
		if (bits_base < 5'(FRAME_BITS_MAX)) begin
			if (qpi_l) begin
				bits_next  = bits_base + 5'h04;
				shift_next = {shift_base[11:0], IO_IN};
			end else begin
				bits_next  = bits_base + 5'h01;
				shift_next = {shift_base[14:0], IO_IN[0]};
			end
		end
		opcode_done = (bits_base < 5'(OPCODE_BITS)) &&
			(bits_next == 5'(OPCODE_BITS));
	end

	// Bits and count are not cleared by chip select: the system clock reads
	// them after the frame, while SCK is stopped and they stand still.
	always_ff @(posedge SCK or posedge RST) begin
		if (RST) begin
			bits_q      <= 5'h00;
			shift_q     <= 16'h0000;
			frame_tog_q <= 1'b0;
		end else begin
			bits_q  <= bits_next;
			shift_q <= shift_next;
			if (first_q)
				frame_tog_q <= ~frame_tog_q;
		end
	end

	// ----------------------------------------------------------------------
	// Link domain: readback output
	// ----------------------------------------------------------------------
	// Parameters and lock change only between frames and are read directly;
	// a synchroniser on the stopped SCK would go stale. Busy is synchronised.
	function automatic logic [7:0] readback(
		input logic [7:0] op,
		input logic [7:0] rd,
		input logic [7:0] ext,
		input logic       write_in_progress
	);
		readback = 8'h00;
		if (op == OP_GET_RDPARAM)
			readback = rd;
		else if (op == OP_GET_EXTPARAM)
			readback = {ext[7:1], write_in_progress};
	endfunction

	assign out_busy = IO_OE != 4'h0;
	assign rb_v = readback(shift_next[7:0], RD_PARAM, EXT_PARAM, wip_l);

	always_ff @(posedge SCK or posedge link_rst) begin
		if (link_rst) begin
			out_q  <= 8'h00;
			IO_OUT <= 4'h0;
			IO_OE  <= 4'h0;
		end else if (opcode_done && !asleep_l &&
			(shift_next[7:0] == OP_GET_RDPARAM ||
			shift_next[7:0] == OP_GET_EXTPARAM)) begin
			out_q <= rb_v;
			if (qpi_l) begin
				IO_OUT <= rb_v[7:4];
				IO_OE  <= 4'hf;
			end else begin
				IO_OUT <= {2'b00, rb_v[7], 1'b0};
				IO_OE  <= 4'h2;
			end
		end else if (out_busy) begin
			// The byte repeats until chip select rises.
			if (qpi_l) begin
				out_q  <= {out_q[3:0], out_q[7:4]};
				IO_OUT <= out_q[3:0];
			end else begin
				out_q  <= {out_q[6:0], out_q[7]};
				IO_OUT <= {2'b00, out_q[6], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------------
	// System domain: frame end detection
	// ----------------------------------------------------------------------
	logic [1:0] sys_sync;
	logic       cs_s;
	logic       tog_s;
	logic       cs_d_q;
	logic       tog_seen_q;
	logic       frame_end;
	slp_frame_s frm;

	slp_sync #(
		.W(2)
	) u_sync_sys (
		.clk(CLK),
		.rst(RST),
		.d  ({CS_N, frame_tog_q}),
		.q  (sys_sync)
	);
	assign cs_s  = sys_sync[1];
	assign tog_s = sys_sync[0];

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cs_d_q     <= 1'b1;
			tog_seen_q <= 1'b0;
		end else begin
			cs_d_q <= cs_s;
			if (frame_end)
				tog_seen_q <= tog_s;
		end
	end

	// A frame counts only if SCK toggled during it.
	assign frame_end = cs_s && !cs_d_q && (tog_s != tog_seen_q);

	always_comb begin
		frm.has_opcode   = bits_q >= 5'(OPCODE_BITS);
		frm.exact_opcode = bits_q == 5'(OPCODE_BITS);
		frm.has_data     = bits_q >= 5'(FRAME_BITS_MAX);
		frm.opcode       = frm.has_data ? shift_q[15:8] : shift_q[7:0];
		frm.data         = shift_q[7:0];
	end

	// ----------------------------------------------------------------------
	// System domain: sleep state machine
	// ----------------------------------------------------------------------
	slp_state_e        state_q;
	logic [TIMER_W-1:0] timer_q;
	logic              wake_reload;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_ACTIVE;
			timer_q <= '0;
		end else begin
			unique case (state_q)
				ST_ACTIVE: begin
					// Extra bits after the opcode cancel the entry.
					if (frame_end && frm.exact_opcode &&
						frm.opcode == OP_DEEP_SLEEP_ENTER) begin
						state_q <= ST_ENTERING;
						timer_q <= TIMER_W'(SLEEP_ENTRY_CYCLES - 1);
					end
				end
				ST_ENTERING: begin
					if (timer_q == '0)
						state_q <= ST_ASLEEP;
					else
						timer_q <= timer_q - TIMER_W'(1);
				end
				ST_ASLEEP: begin
					if (frame_end && frm.has_opcode &&
						frm.opcode == OP_DEEP_SLEEP_RELEASE &&
						!WRITE_IN_PROGRESS) begin
						state_q <= ST_WAKING;
						timer_q <= TIMER_W'(WAKE_CYCLES - 1);
					end
				end
				ST_WAKING: begin
					if (timer_q == '0)
						state_q <= ST_ACTIVE;
					else
						timer_q <= timer_q - TIMER_W'(1);
				end
			endcase
		end
	end

	assign wake_reload = (state_q == ST_WAKING) && (timer_q == '0);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DEEP_SLEEP <= 1'b0;
			WRITE_LOCK <= 1'b0;
			CMD_READY  <= 1'b0;
		end else begin
			DEEP_SLEEP <= state_q == ST_ASLEEP;
			WRITE_LOCK <= state_q != ST_ACTIVE;
			CMD_READY  <= state_q == ST_ACTIVE;
		end
	end

	// ----------------------------------------------------------------------
	// System domain: parameter registers
	// ----------------------------------------------------------------------
	logic [7:0] rd_nv_q;
	logic [2:0] drive_nv_q;
	logic       cmd_ok;

	// Commands act only while awake; while asleep every frame but the
	// release is dropped, readbacks included.
	assign cmd_ok = frame_end && frm.has_data &&
		state_q == ST_ACTIVE;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_nv_q  <= RDPARAM_RESET;
			RD_PARAM <= slp_rdparam_s'(RDPARAM_RESET);
		end else if (wake_reload) begin
			RD_PARAM <= slp_rdparam_s'(rd_nv_q);
		end else if (cmd_ok && frm.opcode == OP_SET_RDPARAM_PERSIST) begin
			rd_nv_q  <= frm.data;
			RD_PARAM <= slp_rdparam_s'(frm.data);
		end else if (cmd_ok && is_rdparam_volatile(frm.opcode)) begin
			RD_PARAM <= slp_rdparam_s'(frm.data);
		end
	end

	// Only the drive field is writable; the low bit reads back busy.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			drive_nv_q <= DRIVE_RESET;
			EXT_PARAM  <= 8'(DRIVE_RESET) << EXT_DRIVE_LSB;
		end else if (wake_reload) begin
			EXT_PARAM  <= 8'(drive_nv_q) << EXT_DRIVE_LSB;
		end else if (cmd_ok && frm.opcode == OP_SET_EXTPARAM_PERSIST) begin
			drive_nv_q <= frm.data[EXT_DRIVE_LSB+:3];
			EXT_PARAM  <= {frm.data[EXT_DRIVE_LSB+:3], 5'h00};
		end else if (cmd_ok && frm.opcode == OP_SET_EXTPARAM_VOLATILE) begin
			EXT_PARAM  <= {frm.data[EXT_DRIVE_LSB+:3], 5'h00};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST)
			SHARED_PIN_IS_RESET <= 1'b0;
		else
			SHARED_PIN_IS_RESET <= !DEDICATED_RESET_PIN &&
				RD_PARAM.pin_function_select;
	end

	// ----------------------------------------------------------------------
	// Read address sequencing
	// ----------------------------------------------------------------------
	slp_wrap_addr #(
		.ADDR_W(ADDR_W)
	) u_wrap (
		.clk       (CLK),
		.rst       (RST),
		.start     (READ_START),
		.start_addr(READ_START_ADDR),
		.step      (READ_NEXT),
		.wrap_cfg  ({RD_PARAM.wrap_enable_bit, RD_PARAM.wrap_length_high,
			RD_PARAM.wrap_length_low}),
		.addr_q    (READ_ADDR)
	);

endmodule

// >>> verif/slp_ctrl_props.sv
// Port-level checker for slp_ctrl, bound from the bench.
// Assumes one CLK domain view of the ports and an active-high reset.
`timescale 1ns/1ns
module slp_ctrl_props
	import slp_pkg::*;
#(
	parameter int   ADDR_W              = 25,
	parameter logic DEDICATED_RESET_PIN = 1'b0
) (
	// Clock and reset
	input wire logic                  CLK,
	input wire logic                  RST,
	// Link and read sequencing
	input wire logic                  CS_N,
	input wire logic [3:0]            IO_OE,
	input wire logic                  READ_START,
	input wire logic [ADDR_W-1:0]     READ_START_ADDR,
	input wire logic                  READ_NEXT,
	input wire logic [ADDR_W-1:0]     READ_ADDR,
	// Configuration and state
	input wire slp_pkg::slp_rdparam_s RD_PARAM,
	input wire logic [7:0]            EXT_PARAM,
	input wire logic                  SHARED_PIN_IS_RESET,
	input wire logic                  DEEP_SLEEP,
	input wire logic                  WRITE_LOCK,
	input wire logic                  CMD_READY
);
	logic [ADDR_W-1:0] mask;
	logic [ADDR_W-1:0] nxt;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// An all-ones mask would make this a plain increment.
	assign mask = ADDR_W'((32'h8 << {RD_PARAM.wrap_length_high,
		RD_PARAM.wrap_length_low}) - 32'h1);
	assign nxt = (READ_ADDR & ~mask) | ((READ_ADDR + 1'b1) & mask);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_lock; DEEP_SLEEP |-> WRITE_LOCK && !CMD_READY; endproperty
	a_lock: assert property (p_lock)
		else $error("asleep but not locked");
	property p_pin;
		##1 SHARED_PIN_IS_RESET ==
			(!DEDICATED_RESET_PIN && $past(RD_PARAM.pin_function_select));
	endproperty
	a_pin: assert property (p_pin)
		else $error("shared pin function wrong");
	property p_ext; EXT_PARAM[4:0] == 5'h0; endproperty
	a_ext: assert property (p_ext)
		else $error("extended register spare bits set");
	property p_start; READ_START |=> READ_ADDR == $past(READ_START_ADDR);
	endproperty
	a_start: assert property (p_start)
		else $error("start address not loaded");
	property p_lin;
		READ_NEXT && !READ_START && !RD_PARAM.wrap_enable_bit
			|=> READ_ADDR == $past(READ_ADDR) + 1'b1;
	endproperty
	a_lin: assert property (p_lin)
		else $error("linear step wrong");
	property p_wrap;
		READ_NEXT && !READ_START && RD_PARAM.wrap_enable_bit
			|=> READ_ADDR == $past(nxt);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("wrap step wrong");
	property p_entry; $rose(WRITE_LOCK) |-> ##[290:310] $rose(DEEP_SLEEP);
	endproperty
	a_entry: assert property (p_entry)
		else $error("sleep entry delay wrong");
	property p_wake; $fell(DEEP_SLEEP) |-> ##[490:510] $rose(CMD_READY);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake delay wrong");
	property p_oe; CS_N |-> IO_OE == 4'h0; endproperty
	a_oe: assert property (p_oe)
		else $error("output enabled while deselected");

	c_sleep: cover property ($rose(DEEP_SLEEP));
	c_wrap: cover property (READ_NEXT && RD_PARAM.wrap_enable_bit);
	c_quad: cover property (IO_OE == 4'hf);
endmodule

// >>> verif/slp_host.sv
// Host controller model: sends frames in one or four-line mode.
// Assumes the caller spaces frames; SCK stands still between them.
`timescale 1ns/1ns
module slp_host (
	// Link pins
	output logic            sck,
	output logic            cs_n,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe
);
	logic [3:0] hv;
	logic [7:0] rd_q;
	logic       oe_seen;
	event       got;

	// Enabled device lanes win; the other lanes carry the host value hv.
	assign io_in = (io_oe & io_out) | (~io_oe & hv);

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		hv = 4'h5;
		rd_q = 8'h00;
		oe_seen = 1'b0;
	end

	task automatic frame(input logic [15:0] b, input int n, input bit q,
		input bit rb);
		int i;
		cs_n = 1'b0;
		oe_seen = 1'b0;
		for (i = 0; i < n; i++) begin
			hv = q ? b[15-4*i -: 4] : {3'h7, b[15-i]};
			#2 sck = 1'b1;
			#3 sck = 1'b0;
			oe_seen = oe_seen | (|io_oe);
			if (q ? (i == 1 || i == 2) : (i >= 7 && i <= 14))
				rd_q = q ? {rd_q[3:0], io_out} : {rd_q[6:0], io_out[1]};
			#1;
		end
		cs_n = 1'b1;
		hv = ~hv;
		if (rb)
			-> got;
		#60;
	endtask
endmodule

// >>> verif/slp_ctrl_tb.sv
// Self-checking bench of slp_ctrl driven through the host model.
// Assumes slp_pkg, slp_host and slp_ctrl_props are compiled first.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
	total_checks++; \
	if ((gt) !== (ex)) begin \
		error_cnt++; \
		$display("unexpected %s exp %h got %h", nm, ex, gt); \
	end \
end
module slp_ctrl_tb;
	import slp_pkg::*;
	localparam int AW = 25;
	logic          clk, rst, qpi, write_in_progress, rstart, rnext;
	logic          sck, cs_n, spr, dsl, wlk, rdy;
	logic [3:0]    io_in, io_out, io_oe;
	logic [AW-1:0] rsa, raddr, a, e, m;
	slp_rdparam_s  rdp;
	logic [7:0]    ext, d, vol_rd, per_rd, vol_ext, per_ext, exp_v;
	logic [7:0]    exp_q[$];
	logic [7:0]    wops[5] = '{8'h65, 8'hc0, 8'h63, 8'h85, 8'h83};
	int            error_cnt, total_checks, seed, cnt, k;

	slp_ctrl #(.ADDR_W(AW)) i_slp_ctrl (.CLK(clk), .RST(rst), .SCK(sck),
		.CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe),
		.QPI_MODE(qpi), .WRITE_IN_PROGRESS(write_in_progress), .READ_START(rstart),
		.READ_START_ADDR(rsa), .READ_NEXT(rnext), .READ_ADDR(raddr),
		.RD_PARAM(rdp), .EXT_PARAM(ext), .SHARED_PIN_IS_RESET(spr),
		.DEEP_SLEEP(dsl), .WRITE_LOCK(wlk), .CMD_READY(rdy));
	slp_host i_slp_host (.sck(sck), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, dat, input int n, input bit q);
		i_slp_host.frame({op, dat}, n, q, 1'b0);
		repeat (8) @(negedge clk);
	endtask

	task automatic rdback(input logic [7:0] op, ex, input bit q);
		exp_q.push_back(ex);
		i_slp_host.frame({op, 8'h00}, q ? 4 : 16, q, 1'b1);
		repeat (8) @(negedge clk);
	endtask

	// Each readback answer is matched against the oldest note.
	initial begin
		forever begin
			@(i_slp_host.got);
			exp_v = exp_q.pop_front();
			`CHK("readback", exp_v, i_slp_host.rd_q)
		end
	end

	initial begin
		#100000;
		error_cnt++;
		report_and_stop();
	end

	initial begin
		seed = 32'hf1ccc82d;
		{rst, qpi, write_in_progress, rstart, rnext, rsa} = {1'b1, 4'h0, AW'(0)};
		error_cnt = 0;
		total_checks = 0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		`CHK("rd_param", 8'h00, rdp)
		`CHK("ext_param", 8'ha0, ext)
		`CHK("cmd_ready", 1'b1, rdy)
		{vol_rd, per_rd, vol_ext, per_ext} = {16'h0000, 16'ha0a0};
		for (k = 0; k < 5; k++) begin
			d = 8'($random(seed));
			cmd(wops[k], d, 16, 1'b0);
			if (k < 3) vol_rd = d;
			if (k == 0) per_rd = d;
			if (k >= 3) vol_ext = {d[7:5], 5'h0};
			if (k == 3) per_ext = vol_ext;
			`CHK("rd_param", vol_rd, rdp)
			`CHK("ext_param", vol_ext, ext)
			`CHK("shared_pin", vol_rd[7], spr)
			rdback(OP_GET_RDPARAM, vol_rd, 1'b0);
			rdback(OP_GET_EXTPARAM, vol_ext, 1'b0);
		end
		@(negedge clk) write_in_progress = 1'b1;
		rdback(OP_GET_EXTPARAM, {vol_ext[7:1], 1'b1}, 1'b0);
		@(negedge clk) write_in_progress = 1'b0;
		// Every wrap code; wrapping codes start two bytes below a block end, linear ones at the top address.
		for (k = 0; k < 8; k++) begin
			cmd(OP_SET_RDPARAM_VOLATILE, {5'h0, k[2:0]}, 16, 1'b0);
			a = AW'($random(seed));
			a[7:0] = 8'hfe;
			if (!k[2]) a = '1;
			m = k[2] ? AW'((8 << k[1:0]) - 1) : '1;
			e = a;
			@(negedge clk) {rsa, rstart} = {a, 1'b1};
			@(negedge clk) {rstart, rnext} = 2'b01;
			repeat (9) begin
				`CHK("read_addr", e, raddr)
				e = (e & ~m) | ((e + 1'b1) & m);
				@(negedge clk);
			end
			rnext = 1'b0;
		end
		cmd(OP_DEEP_SLEEP_ENTER, 8'h00, 7, 1'b0);
		cmd(OP_DEEP_SLEEP_ENTER, 8'h00, 9, 1'b0);
		`CHK("write_lock", 1'b0, wlk)
		@(negedge clk) qpi = 1'b1;
		i_slp_host.frame(16'h0000, 3, 1'b1, 1'b0);
		rdback(OP_GET_RDPARAM, 8'h07, 1'b1);
		cmd(OP_DEEP_SLEEP_ENTER, 8'h00, 2, 1'b1);
		cnt = 0;
		while (dsl !== 1'b1 && cnt < 400) begin
			@(negedge clk);
			cnt++;
		end
		`CHK("deep_sleep", 1'b1, dsl)
		cmd(OP_SET_RDPARAM_PERSIST, ~per_rd, 4, 1'b1);
		i_slp_host.frame({OP_GET_RDPARAM, 8'h00}, 4, 1'b1, 1'b0);
		`CHK("sleep_answer", 1'b0, i_slp_host.oe_seen)
		@(negedge clk) write_in_progress = 1'b1;
		cmd(OP_DEEP_SLEEP_RELEASE, 8'h00, 2, 1'b1);
		`CHK("deep_sleep", 1'b1, dsl)
		@(negedge clk) write_in_progress = 1'b0;
		cmd(OP_DEEP_SLEEP_RELEASE, 8'h00, 2, 1'b1);
		cnt = 0;
		while (rdy !== 1'b1 && cnt < 700) begin
			@(negedge clk);
			cnt++;
		end
		`CHK("wake_wait", 1'b1, (cnt >= 400 && rdy === 1'b1))
		`CHK("rd_param", per_rd, rdp)
		rdback(OP_GET_EXTPARAM, per_ext, 1'b1);
		@(negedge clk) qpi = 1'b0;
		i_slp_host.frame(16'h0000, 3, 1'b0, 1'b0);
		rdback(OP_GET_RDPARAM, per_rd, 1'b0);
		`CHK("pending", 0, exp_q.size())
		// A second reset in mid-run must drop every parameter setting.
		@(negedge clk) rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		`CHK("rd_param", 8'h00, rdp)
		`CHK("ext_param", 8'ha0, ext)
		`CHK("cmd_ready", 1'b1, rdy)
		report_and_stop();
	end
endmodule

bind slp_ctrl slp_ctrl_props #(.ADDR_W(ADDR_W),
	.DEDICATED_RESET_PIN(DEDICATED_RESET_PIN)) i_slp_ctrl_props (.CLK,
	.RST, .CS_N, .IO_OE, .READ_START, .READ_START_ADDR, .READ_NEXT,
	.READ_ADDR, .RD_PARAM, .EXT_PARAM, .SHARED_PIN_IS_RESET, .DEEP_SLEEP,
	.WRITE_LOCK, .CMD_READY);
